// ==== design/rslvd_top.sv ====
// rslvd_top: reset source merge, reset sequencer and low-voltage flags
//
// Operation
// - Reset comes from power-on, watchdog overflow, brown-out or the pin, the pin only when enabled.
// - During reset registers take initial values, the core halts, and fetch starts at address zero.
// - The cause is kept as two bits: 00 watchdog, 01 reserved, 10 power/low voltage, 11 pin.
// - Any low-voltage reset clears both supply indicator flags.
// - Power-up waits for stable supply, checks the pin, initialises, warms up, then runs.
// - With the pin enabled the device stays in reset while the pin is low.
// - A watchdog overflow resets, initialises, warms up and restarts in normal mode.
// - The lowest detector level resets under the low and mid options, for power-on and brown-out.
// - Under the low option the reset is at the lowest level and both flags read zero.
// - Under the mid option the reset stays at the lowest level and the mid flag tracks supply.
// - Under the high option the reset moves to the mid level and the high flag tracks supply.
// - The high flag tracks its threshold only under the high option.
// - Reset length depends on oscillator type, short for rc and long for crystal.
// - With the pin function enabled a low level on the pin resets the device.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/100ps
module rslvd_top (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic [rslvd_pkg::ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic supply_stable,
   input wire logic det_low_trip,
   input wire logic det_mid_trip,
   input wire logic det_high_trip,
   input wire logic wdt_overflow,
   input wire logic reset_pin_in,
   input wire logic reset_pin_enable,
   input wire logic osc_is_crystal,
   input wire rslvd_pkg::rslvd_opt_t low_voltage_detector_option,
   output logic core_hold,
   output logic fetch_start,
   output logic [10:0] fetch_addr,
   output logic irq
);
   typedef struct packed {
      rslvd_pkg::rslvd_state_t state;
      logic [1:0] cause;
      logic mid_flag;
      logic high_flag;
      logic [2:0] alu;
      logic [1:0] irq_stat;
      logic [1:0] irq_mask;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic irq;
      logic core_hold;
      logic fetch_start;
      logic [10:0] fetch_addr;
      logic wu_arm;
      logic wu_xtal;
   } rslvd_top_st_t;

   rslvd_top_st_t r_reg;
   rslvd_top_st_t r_next;
   logic lvd_trip;
   logic ext_low;
   logic wr_done;
   logic [1:0] ev;
   logic [7:0] flag_val;

   rslvd_wu_if wu_if ();

   rslvd_warmup u_warmup (
      .ref_clk(ref_clk),
      .srst(srst),
      .wu(wu_if.warm)
   );

   // register index hit, 2'd0 flag, 2'd1 status, 2'd2 mask, 2'd3 none
   function automatic logic [1:0] reg_sel(
      input logic [rslvd_pkg::ADDR_W-1:0] a
   );
      logic [1:0] s;
      s = 2'h3;
      if (a == rslvd_pkg::ADDR_FLAG)
         s = 2'h0;
      else if (a == rslvd_pkg::ADDR_IRQ_STAT)
         s = 2'h1;
      else if (a == rslvd_pkg::ADDR_IRQ_MASK)
         s = 2'h2;
      return s;
   endfunction

   // reset level per detector option and pin reset level
   always_comb
   begin
      if (low_voltage_detector_option == rslvd_pkg::detector_option_high)
         lvd_trip = det_mid_trip;
      else
         lvd_trip = det_low_trip;
      ext_low = reset_pin_enable && !reset_pin_in;
   end

   // flag register read image
   always_comb
   begin
      flag_val = 8'h00;
      flag_val[rslvd_pkg::B_CAUSE_HI] = r_reg.cause[1];
      flag_val[rslvd_pkg::B_CAUSE_LO] = r_reg.cause[0];
      flag_val[rslvd_pkg::B_HIGH_FLAG] = r_reg.high_flag;
      flag_val[rslvd_pkg::B_MID_FLAG] = r_reg.mid_flag;
      flag_val[rslvd_pkg::B_ALU_MSB:0] = r_reg.alu;
   end

   // sequencer, flags, interrupts and apb slave
   always_comb
   begin
      r_next = r_reg;
      r_next.fetch_start = 1'b0;
      r_next.pready = 1'b0;
      r_next.pslverr = 1'b0;
      wr_done = psel && penable && r_reg.pready && pwrite;
      ev = 2'h0;
      if (lvd_trip || !supply_stable)
      begin
         r_next.state = rslvd_pkg::ST_POWERUP;
         r_next.cause = rslvd_pkg::CAUSE_POWER;
      end
      else if (ext_low && r_reg.state != rslvd_pkg::ST_POWERUP
               && r_reg.state != rslvd_pkg::ST_PINCHK)
      begin
         r_next.state = rslvd_pkg::ST_PINCHK;
         r_next.cause = rslvd_pkg::CAUSE_EXT;
      end
      else if (wdt_overflow && r_reg.state == rslvd_pkg::ST_RUN)
      begin
         r_next.state = rslvd_pkg::ST_INIT;
         r_next.cause = rslvd_pkg::CAUSE_WDT;
      end
      else
      begin
         unique case (r_reg.state)
            rslvd_pkg::ST_POWERUP:
               r_next.state = rslvd_pkg::ST_PINCHK;
            rslvd_pkg::ST_PINCHK:
               if (!ext_low)
                  r_next.state = rslvd_pkg::ST_INIT;
            rslvd_pkg::ST_INIT:
               r_next.state = rslvd_pkg::ST_WARMUP;
            rslvd_pkg::ST_WARMUP:
               if (wu_if.done)
               begin
                  r_next.state = rslvd_pkg::ST_RUN;
                  r_next.fetch_start = 1'b1;
               end
            rslvd_pkg::ST_RUN:
               r_next.state = rslvd_pkg::ST_RUN;
         endcase
      end
      // registers held at initial values while not running
      if (r_reg.state != rslvd_pkg::ST_RUN || r_next.state != rslvd_pkg::ST_RUN)
      begin
         r_next.alu = rslvd_pkg::ALU_RST;
         r_next.irq_stat = rslvd_pkg::IRQ_RST;
         r_next.irq_mask = rslvd_pkg::IRQ_RST;
         r_next.mid_flag = 1'b0;
         r_next.high_flag = 1'b0;
      end
      else
      begin
         r_next.mid_flag = det_mid_trip && low_voltage_detector_option
            != rslvd_pkg::detector_option_low;
         r_next.high_flag = det_high_trip && low_voltage_detector_option
            == rslvd_pkg::detector_option_high;
         ev[rslvd_pkg::B_EV_MID] = r_next.mid_flag && !r_reg.mid_flag;
         ev[rslvd_pkg::B_EV_HIGH] = r_next.high_flag && !r_reg.high_flag;
         // software writes only store values, never start a reset
         if (wr_done)
         begin
            unique case (reg_sel(paddr))
               2'h0:
               begin
                  r_next.cause =
                     pwdata[rslvd_pkg::B_CAUSE_HI:rslvd_pkg::B_CAUSE_LO];
                  r_next.alu = pwdata[rslvd_pkg::B_ALU_MSB:0];
               end
               2'h1:
                  r_next.irq_stat = r_reg.irq_stat & ~pwdata[1:0];
               2'h2:
                  r_next.irq_mask = pwdata[1:0];
               2'h3:
                  r_next.irq_mask = r_reg.irq_mask;
            endcase
         end
         // a new event wins over a clear in the same cycle
         r_next.irq_stat = r_next.irq_stat | ev;
      end
      // apb setup phase: prepare answer for the access phase
      if (psel && !penable)
      begin
         r_next.pready = 1'b1;
         unique case (reg_sel(paddr))
            2'h0:
               r_next.prdata = {24'h000000, flag_val};
            2'h1:
               r_next.prdata = {30'h0, r_reg.irq_stat};
            2'h2:
               r_next.prdata = {30'h0, r_reg.irq_mask};
            2'h3:
            begin
               r_next.prdata = 32'h00000000;
               r_next.pslverr = 1'b1;
            end
         endcase
      end
      r_next.irq = |(r_next.irq_stat & r_next.irq_mask);
      r_next.core_hold = r_next.state != rslvd_pkg::ST_RUN;
      r_next.fetch_addr = rslvd_pkg::PROGRAM_START_ADDRESS;
      r_next.wu_arm = r_next.state == rslvd_pkg::ST_WARMUP;
      r_next.wu_xtal = osc_is_crystal;
   end

   // state register, power-on cause on srst
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         r_reg <= '0;
         r_reg.state <= rslvd_pkg::ST_POWERUP;
         r_reg.cause <= rslvd_pkg::CAUSE_POWER;
         r_reg.core_hold <= 1'b1;
      end
      else
         r_reg <= r_next;
   end

   // outputs straight from the state register
   assign wu_if.arm = r_reg.wu_arm;
   assign wu_if.xtal = r_reg.wu_xtal;
   assign prdata = r_reg.prdata;
   assign pready = r_reg.pready;
   assign pslverr = r_reg.pslverr;
   assign irq = r_reg.irq;
   assign core_hold = r_reg.core_hold;
   assign fetch_start = r_reg.fetch_start;
   assign fetch_addr = r_reg.fetch_addr;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (srst);

   AST_LVD_RESET: assert property (lvd_trip |=> core_hold
      && r_reg.cause == rslvd_pkg::CAUSE_POWER)
      else $error("low voltage did not reset with power cause");
   AST_EXT_RESET: assert property (ext_low && supply_stable && !lvd_trip
      && r_reg.state inside {rslvd_pkg::ST_INIT, rslvd_pkg::ST_WARMUP,
      rslvd_pkg::ST_RUN} |=> core_hold && r_reg.cause == rslvd_pkg::CAUSE_EXT)
      else $error("pin low did not reset with pin cause");
   AST_PIN_HOLD: assert property (r_reg.state == rslvd_pkg::ST_PINCHK
      && ext_low |=> core_hold && r_reg.state != rslvd_pkg::ST_RUN)
      else $error("released reset while pin low");
   AST_WDT_RESET: assert property (wdt_overflow && !ext_low && !lvd_trip
      && supply_stable && r_reg.state == rslvd_pkg::ST_RUN
      |=> r_reg.cause == rslvd_pkg::CAUSE_WDT ##1 r_reg.state
      == rslvd_pkg::ST_WARMUP)
      else $error("watchdog reset sequence wrong");
   AST_FETCH_ZERO: assert property ($rose(fetch_start) |-> !core_hold
      && fetch_addr == 11'h000 && $past(r_reg.state) == rslvd_pkg::ST_WARMUP)
      else $error("fetch start wrong");
   AST_FLAGS_CLEAR: assert property (lvd_trip |=> !r_reg.mid_flag
      && !r_reg.high_flag)
      else $error("flags not cleared by low-voltage reset");
   AST_LOW_OPT: assert property (low_voltage_detector_option
      == rslvd_pkg::detector_option_low |=> !r_reg.mid_flag)
      else $error("mid flag set under low option");
   AST_HIGH_ONLY: assert property (low_voltage_detector_option
      != rslvd_pkg::detector_option_high |=> !r_reg.high_flag)
      else $error("high flag set outside high option");
   AST_MID_TRACK: assert property (r_reg.state == rslvd_pkg::ST_RUN
      && r_next.state == rslvd_pkg::ST_RUN && low_voltage_detector_option
      == rslvd_pkg::detector_option_mid |=> r_reg.mid_flag == $past(det_mid_trip))
      else $error("mid flag does not follow supply");
   // high flag follows its comparator while running under the high option
   AST_HIGH_TRACK: assert property (r_reg.state == rslvd_pkg::ST_RUN
      && r_next.state == rslvd_pkg::ST_RUN && low_voltage_detector_option
      == rslvd_pkg::detector_option_high
      |=> r_reg.high_flag == $past(det_high_trip))
      else $error("high flag does not follow supply");
   // with no reset cause present the core keeps running, writes or not
   AST_SW_NO_RESET: assert property (r_reg.state == rslvd_pkg::ST_RUN
      && supply_stable && !lvd_trip && !ext_low && !wdt_overflow
      |=> !core_hold && r_reg.state == rslvd_pkg::ST_RUN)
      else $error("register access started a reset");

   COV_POWER_TO_RUN: cover property ($rose(fetch_start)
      && r_reg.cause == rslvd_pkg::CAUSE_POWER);
   COV_WDT_RESTART: cover property ($rose(fetch_start)
      && r_reg.cause == rslvd_pkg::CAUSE_WDT);
   COV_EXT_RESET: cover property (r_reg.state == rslvd_pkg::ST_PINCHK
      && r_reg.cause == rslvd_pkg::CAUSE_EXT);
   COV_IRQ: cover property ($rose(irq));
   COV_XTAL_START: cover property ($rose(fetch_start) && wu_if.xtal);
endmodule

// ==== design/rslvd_pkg.sv ====
// rslvd_pkg: shared constants and types of the reset source and lvd block
package rslvd_pkg;
   // register indices (byte address is four times the index)
   localparam logic [7:0] IDX_FLAG = 8'h86;
   localparam logic [7:0] IDX_IRQ_STAT = 8'h87;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h88;
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] ADDR_FLAG = {2'h0, IDX_FLAG, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = {2'h0, IDX_IRQ_STAT, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = {2'h0, IDX_IRQ_MASK, 2'h0};
   // field positions of system_flag_status
   localparam int B_CAUSE_HI = 7;
   localparam int B_CAUSE_LO = 6;
   localparam int B_HIGH_FLAG = 5;
   localparam int B_MID_FLAG = 4;
   localparam int B_ALU_MSB = 2;
   // irq status/mask bit positions
   localparam int B_EV_MID = 0;
   localparam int B_EV_HIGH = 1;
   // reset cause codes {reset_cause_high_bit, reset_cause_low_bit}
   localparam logic [1:0] CAUSE_WDT = 2'h0;
   localparam logic [1:0] CAUSE_POWER = 2'h2;
   localparam logic [1:0] CAUSE_EXT = 2'h3;
   // reset values
   localparam logic [2:0] ALU_RST = 3'h0;
   localparam logic [1:0] IRQ_RST = 2'h0;
   localparam logic [10:0] PROGRAM_START_ADDRESS = 11'h000;
   // oscillator warm-up counts in clock cycles
   localparam int WU_W = 12;
   localparam logic [WU_W-1:0] WU_RC_CYCLES = 12'h040;
   localparam logic [WU_W-1:0] WU_XTAL_CYCLES = 12'h800;
   // detector configuration option
   typedef enum logic [1:0] {
      detector_option_low = 2'b00,
      detector_option_mid = 2'b01,
      detector_option_high = 2'b10
   } rslvd_opt_t;
   // reset sequencer states
   typedef enum logic [2:0] {
      ST_POWERUP = 3'b000,
      ST_PINCHK = 3'b001,
      ST_INIT = 3'b010,
      ST_WARMUP = 3'b011,
      ST_RUN = 3'b100
   } rslvd_state_t;
endpackage

// ==== design/rslvd_wu_if.sv ====
// rslvd_wu_if: link between the sequencer and the warm-up counter
`timescale 1ns/100ps
interface rslvd_wu_if;
   logic arm;
   logic xtal;
   logic done;
   modport ctrl (output arm, output xtal, input done);
   modport warm (input arm, input xtal, output done);
endinterface

// ==== design/rslvd_warmup.sv ====
// rslvd_warmup: oscillator warm-up counter, count chosen per oscillator
`timescale 1ns/100ps
module rslvd_warmup (
   input wire logic ref_clk,
   input wire logic srst,
   rslvd_wu_if.warm wu
);
   typedef struct packed {
      logic [rslvd_pkg::WU_W-1:0] cnt;
      logic done;
   } rslvd_wu_st_t;

   rslvd_wu_st_t r_reg;
   rslvd_wu_st_t r_next;
   logic [rslvd_pkg::WU_W-1:0] limit;

   // count armed cycles until the oscillator limit, then flag done
   always_comb
   begin
      r_next = r_reg;
      limit = wu.xtal ? rslvd_pkg::WU_XTAL_CYCLES : rslvd_pkg::WU_RC_CYCLES;
      if (!wu.arm)
      begin
         r_next.cnt = '0;
         r_next.done = 1'b0;
      end
      else if (r_reg.cnt == limit - 12'h001)
         r_next.done = 1'b1;
      else
         r_next.cnt = r_reg.cnt + 12'h001;
   end

   // state register
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         r_reg <= '0;
      else
         r_reg <= r_next;
   end

   assign wu.done = r_reg.done;

   AST_WU_RC_COUNT: assert property (@(posedge ref_clk) disable iff (srst)
      $rose(wu.arm) && !wu.xtal |-> ##64 (wu.done || !wu.arm))
      else $error("rc warm-up did not finish in its count");
   AST_WU_NOT_EARLY: assert property (@(posedge ref_clk) disable iff (srst)
      $rose(wu.arm) |-> !wu.done [*8])
      else $error("warm-up done too early");
endmodule

// ==== bench/rslvd_partner.sv ====
// rslvd_partner: supply monitor, watchdog and reset pin seen by the block
`timescale 1ns/100ps
module rslvd_partner (
   input wire logic [5:0] vdd_dv,
   input wire logic wdt_fire,
   input wire logic pin_low,
   output logic supply_stable,
   output logic det_low_trip,
   output logic det_mid_trip,
   output logic det_high_trip,
   output logic wdt_overflow,
   output logic reset_pin_in
);
   // comparators on the supply, given in tenths of a volt
   assign det_low_trip = (vdd_dv < 6'd21);
   assign det_mid_trip = (vdd_dv <= 6'd24);
   assign det_high_trip = (vdd_dv <= 6'd36);
   assign supply_stable = (vdd_dv >= 6'd21);
   // watchdog overflow and pin level as commanded by the bench
   assign wdt_overflow = wdt_fire;
   assign reset_pin_in = ~pin_low;
endmodule

// ==== bench/tb_top.sv ====
// tb_top: apb driven bench for the reset source and lvd block
`timescale 1ns/100ps
module tb_top;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic [rslvd_pkg::ADDR_W-1:0] paddr = '0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic pready, pslverr, supply_stable, det_low_trip, det_mid_trip;
   logic det_high_trip, wdt_overflow, reset_pin_in;
   logic core_hold, fetch_start, irq;
   logic [10:0] fetch_addr;
   logic [5:0] vdd_dv = 6'h28;
   logic wdt_fire = 1'b0;
   logic pin_low = 1'b0;
   logic pin_en = 1'b0;
   logic xtal = 1'b0;
   rslvd_pkg::rslvd_opt_t opt = rslvd_pkg::detector_option_low;
   int bad_count = 0;
   int n_compared = 0;
   int cyc = 0;
   int n;
   logic [31:0] rd;
   logic err;

   rslvd_top uut (.ref_clk(ref_clk), .srst(srst), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .supply_stable(supply_stable), .det_low_trip(det_low_trip),
      .det_mid_trip(det_mid_trip), .det_high_trip(det_high_trip),
      .wdt_overflow(wdt_overflow), .reset_pin_in(reset_pin_in),
      .reset_pin_enable(pin_en), .osc_is_crystal(xtal),
      .low_voltage_detector_option(opt), .core_hold(core_hold),
      .fetch_start(fetch_start), .fetch_addr(fetch_addr), .irq(irq));

   rslvd_partner far (.vdd_dv(vdd_dv), .wdt_fire(wdt_fire),
      .pin_low(pin_low), .supply_stable(supply_stable),
      .det_low_trip(det_low_trip), .det_mid_trip(det_mid_trip),
      .det_high_trip(det_high_trip), .wdt_overflow(wdt_overflow),
      .reset_pin_in(reset_pin_in));

   // free running clock, 40 ns period
   always #20 ref_clk = ~ref_clk;

   // verdict and end of run
   task automatic summarize();
      $display("compared %0d mismatched %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // hang guard
   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 30000)
      begin
         bad_count = bad_count + 1;
         summarize();
      end
   end

   // one comparison, reported at once on mismatch
   task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one apb transfer: setup, access until pready, then release
   task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] wd, output logic [31:0] d, output logic e);
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= wr;
      pwdata <= wd;
      @(posedge ref_clk);
      penable <= 1'b1;
      // look at pready where it is settled, before the edge that samples it
      @(negedge ref_clk);
      while (pready !== 1'b1)
      begin
         @(posedge ref_clk);
         @(negedge ref_clk);
      end
      d = prdata;
      e = pslverr;
      @(posedge ref_clk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // wait for program start and check where it starts
   task automatic wait_run(output int cnt);
      cnt = 0;
      @(negedge ref_clk);
      while (fetch_start !== 1'b1 && cnt < 5000)
      begin
         cnt++;
         @(negedge ref_clk);
      end
      chk("fetch_start", 32'h1, {31'h0, fetch_start});
      chk("fetch_addr", 32'h0, {21'h0, fetch_addr});
      chk("core_hold", 32'h0, {31'h0, core_hold});
   endtask

   task automatic settle();
      repeat (3) @(posedge ref_clk);
   endtask

   task automatic rd_flag();
      apb(1'b0, rslvd_pkg::ADDR_FLAG, 32'h0, rd, err);
   endtask

   // main sequence
   initial
   begin
      repeat (3) @(posedge ref_clk);
      srst <= 1'b0;
      wait_run(n);
      chk("rc start", 32'h1, 32'(n >= 64 && n <= 80));
      rd_flag();
      chk("cause power", 32'h80, rd);
      apb(1'b0, 12'h000, 32'h0, rd, err);
      chk("unmapped err", 32'h1, {31'h0, err});
      apb(1'b1, rslvd_pkg::ADDR_FLAG, 32'h47, rd, err);
      rd_flag();
      chk("flag write", 32'h47, rd);
      chk("no sw reset", 32'h0, {31'h0, core_hold});
      $display("test power-on and registers done");
      vdd_dv <= 6'd30;
      for (int i = 0; i < 3; i++)
      begin
         opt <= rslvd_pkg::rslvd_opt_t'(i);
         settle();
         rd_flag();
         chk("flags 3.0", {30'h0, i == 2, 1'b0}, {30'h0, rd[5:4]});
      end
      opt <= rslvd_pkg::detector_option_mid;
      vdd_dv <= 6'd23;
      settle();
      rd_flag();
      chk("mid flag", 32'h1, {30'h0, rd[5:4]});
      opt <= rslvd_pkg::detector_option_low;
      settle();
      rd_flag();
      chk("low flags", 32'h0, {30'h0, rd[5:4]});
      chk("no reset 2.3", 32'h0, {31'h0, core_hold});
      $display("test detector flags done");
      vdd_dv <= 6'd40;
      opt <= rslvd_pkg::detector_option_high;
      apb(1'b1, rslvd_pkg::ADDR_IRQ_MASK, 32'h2, rd, err);
      apb(1'b1, rslvd_pkg::ADDR_IRQ_STAT, 32'h3, rd, err);
      vdd_dv <= 6'd30;
      settle();
      chk("irq high", 32'h1, {31'h0, irq});
      apb(1'b1, rslvd_pkg::ADDR_IRQ_STAT, 32'h2, rd, err);
      settle();
      chk("irq cleared", 32'h0, {31'h0, irq});
      opt <= rslvd_pkg::detector_option_mid;
      vdd_dv <= 6'd23;
      settle();
      apb(1'b0, rslvd_pkg::ADDR_IRQ_STAT, 32'h0, rd, err);
      chk("stat mid", 32'h1, rd & 32'h1);
      chk("irq masked", 32'h0, {31'h0, irq});
      vdd_dv <= 6'd40;
      $display("test interrupt done");
      wdt_fire <= 1'b1;
      @(posedge ref_clk);
      wdt_fire <= 1'b0;
      @(posedge ref_clk);
      chk("wdt hold", 32'h1, {31'h0, core_hold});
      wait_run(n);
      rd_flag();
      chk("cause wdt", 32'h0, rd);
      $display("test watchdog done");
      pin_en <= 1'b1;
      pin_low <= 1'b1;
      repeat (50) @(posedge ref_clk);
      chk("pin hold", 32'h1, {31'h0, core_hold});
      pin_low <= 1'b0;
      wait_run(n);
      rd_flag();
      chk("cause pin", 32'hc0, rd & 32'hc0);
      pin_en <= 1'b0;
      pin_low <= 1'b1;
      repeat (10) @(posedge ref_clk);
      chk("pin ignored", 32'h0, {31'h0, core_hold});
      pin_low <= 1'b0;
      $display("test reset pin done");
      opt <= rslvd_pkg::detector_option_low;
      vdd_dv <= 6'd20;
      settle();
      chk("lvd low hold", 32'h1, {31'h0, core_hold});
      vdd_dv <= 6'd40;
      wait_run(n);
      opt <= rslvd_pkg::detector_option_high;
      vdd_dv <= 6'd23;
      settle();
      chk("lvd high hold", 32'h1, {31'h0, core_hold});
      vdd_dv <= 6'd40;
      wait_run(n);
      rd_flag();
      chk("cause lvd", 32'h80, rd);
      $display("test low voltage reset done");
      xtal <= 1'b1;
      wdt_fire <= 1'b1;
      @(posedge ref_clk);
      wdt_fire <= 1'b0;
      wait_run(n);
      chk("xtal start", 32'h1, 32'(n >= 2048 && n <= 2100));
      $display("test crystal warm-up done");
      summarize();
   end
endmodule
